// >>> cfg_host_model.sv
/*
 Host-side model: hands whole configuration words to the register as strobes.
 Assumes the bench calls send() and shares CORE_CLK with the register.
*/
`timescale 1ns/1ps
module cfg_host_model (
	input  wire logic                          CORE_CLK,
	output logic                               stb,
	output logic [thermal_cfg_pkg::CFG_W-1:0] wdata
);
	initial begin
		stb = 1'b0;
		wdata = 16'h0000;
	end
	// A random idle gap stands in for a slow serial host
	task automatic send(input logic [15:0] w);
		int gap;
		gap = $urandom_range(0, 3);
		// Caller returns 1 ns after an edge; after a gap, step off the edge by the same 1 ns
		repeat (gap) @(posedge CORE_CLK);
		if (gap != 0)
			#1;
		stb = 1'b1;
		wdata = w;
		@(posedge CORE_CLK);
		#1 stb = 1'b0;
		wdata = ~w; // Stale data must not look valid
	endtask
endmodule

// >>> thermal_cfg_pkg.sv
/*
 Constants for the event and power configuration register of a temperature sensor.
 Assumes a serial front end that turns host transfers into word strobes on one clock.
*/
package thermal_cfg_pkg;
	localparam int CFG_W = 16;
	localparam int HYST_W = 5;
	// Field positions
	localparam int B_MODE = 0;
	localparam int B_POL = 1;
	localparam int B_CRIT_ONLY = 2;
	localparam int B_OUT_EN = 3;
	localparam int B_STATUS = 4;
	localparam int B_CLEAR = 5;
	localparam int B_ALARM_LOCK = 6;
	localparam int B_CRIT_LOCK = 7;
	localparam int B_SHUTDOWN = 8;
	localparam int B_HYST_LO = 9;
	localparam int B_HYST_HI = 10;
	// Values after reset
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
	localparam logic [1:0] HYST_RESET = 2'h0;
	// Hysteresis codes and their size in quarter-degree steps
	localparam logic [1:0] HYST_NONE = 2'h0;
	localparam logic [1:0] HYST_1P5 = 2'h1;
	localparam logic [1:0] HYST_3P0 = 2'h2;
	localparam logic [1:0] HYST_6P0 = 2'h3;
	localparam logic [HYST_W-1:0] HQ_NONE = 5'h00;
	localparam logic [HYST_W-1:0] HQ_1P5 = 5'h06;
	localparam logic [HYST_W-1:0] HQ_3P0 = 5'h0C;
	localparam logic [HYST_W-1:0] HQ_6P0 = 5'h18;
endpackage

// >>> thermal_event_config_register.sv
/*
 Configuration register for the event output, trip locks, shutdown and hysteresis.
 Assumes the serial front end and the converter share CORE_CLK; trip comparisons arrive
 already registered, so no synchronisers are used. RST_B is the power-on reset.
*/
`timescale 1ns/1ps
module thermal_event_config_register (
	input  wire logic                          CORE_CLK,
	input  wire logic                          RST_B,
	input  wire logic                          CFG_WR_STB,
	input  wire logic [thermal_cfg_pkg::CFG_W-1:0] CFG_WDATA,
	output logic      [thermal_cfg_pkg::CFG_W-1:0] CFG_RDATA,
	input  wire logic                          ABOVE_CRIT,
	input  wire logic                          ABOVE_ALARM,
	input  wire logic                          BELOW_ALARM,
	input  wire logic                          ALARM_TRIP_WR_REQ,
	input  wire logic                          CRIT_TRIP_WR_REQ,
	output logic                               ALARM_TRIP_WR_EN,
	output logic                               CRIT_TRIP_WR_EN,
	output logic                               THERMAL_SENSING_EN,
	output logic      [thermal_cfg_pkg::HYST_W-1:0] HYST_QDEG,
	output logic                               EVENT_O,
	output logic                               EVENT_OE_B
);
	import thermal_cfg_pkg::*;

	// Hysteresis code to quarter-degree steps
	function automatic logic [HYST_W-1:0] hyst_steps(input logic [1:0] code);
		case (code)
			HYST_NONE: hyst_steps = HQ_NONE;
			HYST_1P5: hyst_steps = HQ_1P5;
			HYST_3P0: hyst_steps = HQ_3P0;
			HYST_6P0: hyst_steps = HQ_6P0;
			default: hyst_steps = HQ_NONE;
		endcase
	endfunction

	logic       mode_q, mode_d;
	logic       pol_q, pol_d;
	logic       crit_only_q, crit_only_d;
	logic       out_en_q, out_en_d;
	logic       alarm_lock_q, alarm_lock_d;
	logic       crit_lock_q, crit_lock_d;
	logic       shutdown_q, shutdown_d;
	logic [1:0] hyst_q, hyst_d;
	logic       pend_q, pend_d;
	logic       cond_q, cond_d;
	logic       event_q, event_d;
	logic [CFG_W-1:0] rdata_q, rdata_d;
	logic [HYST_W-1:0] hyst_qdeg_q, hyst_qdeg_d;
	logic       pin_q, pin_d;
	logic       oe_b_q, oe_b_d;
	logic       locked;
	logic       cond;
	logic       clr_req;

	assign locked = alarm_lock_q | crit_lock_q;

	// Event condition; shutdown stops sensing, so nothing can trip
	always_comb begin
		if (shutdown_q) begin
			cond = 1'b0;
		end else if (crit_only_q) begin
			cond = ABOVE_CRIT;
		end else begin
			cond = ABOVE_CRIT | ABOVE_ALARM | BELOW_ALARM;
		end
	end

	// Clear request acts only in interrupt mode and never above the critical limit
	assign clr_req = CFG_WR_STB & CFG_WDATA[B_CLEAR] & mode_q & ~ABOVE_CRIT;

	// Next values of the configuration fields and event state
	always_comb begin
		mode_d = mode_q;
		pol_d = pol_q;
		crit_only_d = crit_only_q;
		out_en_d = out_en_q;
		alarm_lock_d = alarm_lock_q;
		crit_lock_d = crit_lock_q;
		shutdown_d = shutdown_q;
		hyst_d = hyst_q;
		if (CFG_WR_STB) begin
			// Status, clear and reserved bits store nothing
			if (!locked) begin
				mode_d = CFG_WDATA[B_MODE];
				pol_d = CFG_WDATA[B_POL];
				crit_only_d = CFG_WDATA[B_CRIT_ONLY];
				out_en_d = CFG_WDATA[B_OUT_EN];
				shutdown_d = CFG_WDATA[B_SHUTDOWN];
			end else begin
				shutdown_d = shutdown_q & CFG_WDATA[B_SHUTDOWN];
			end
			// Locks are sticky: a zero never clears them, one write sets them
			alarm_lock_d = alarm_lock_q | CFG_WDATA[B_ALARM_LOCK];
			crit_lock_d = crit_lock_q | CFG_WDATA[B_CRIT_LOCK];
			hyst_d = CFG_WDATA[B_HYST_HI:B_HYST_LO];
		end
		cond_d = cond;
		// A new trip edge wins over a clear in the same cycle
		if (!mode_q || shutdown_q) begin
			pend_d = 1'b0;
		end else if (cond && !cond_q) begin
			pend_d = 1'b1;
		end else if (clr_req) begin
			pend_d = 1'b0;
		end else begin
			pend_d = pend_q;
		end
		// Comparator follows the condition; interrupt holds the latched event
		if (mode_q) begin
			event_d = pend_d | (ABOVE_CRIT & ~shutdown_q);
		end else begin
			event_d = cond;
		end
		rdata_d = '0;
		rdata_d[B_MODE] = mode_d;
		rdata_d[B_POL] = pol_d;
		rdata_d[B_CRIT_ONLY] = crit_only_d;
		rdata_d[B_OUT_EN] = out_en_d;
		rdata_d[B_STATUS] = event_d & out_en_d;
		rdata_d[B_ALARM_LOCK] = alarm_lock_d;
		rdata_d[B_CRIT_LOCK] = crit_lock_d;
		rdata_d[B_SHUTDOWN] = shutdown_d;
		rdata_d[B_HYST_HI:B_HYST_LO] = hyst_d;
		// Pin, enable and hysteresis outputs leave from flops so they cannot glitch
		hyst_qdeg_d = hyst_steps(hyst_d);
		pin_d = event_d ? pol_d : ~pol_d;
		oe_b_d = ~out_en_d;
	end

	// Registers; only power-on reset clears the locks
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_q <= CFG_RESET[B_MODE];
			pol_q <= CFG_RESET[B_POL];
			crit_only_q <= CFG_RESET[B_CRIT_ONLY];
			out_en_q <= CFG_RESET[B_OUT_EN];
			alarm_lock_q <= CFG_RESET[B_ALARM_LOCK];
			crit_lock_q <= CFG_RESET[B_CRIT_LOCK];
			shutdown_q <= CFG_RESET[B_SHUTDOWN];
			hyst_q <= HYST_RESET;
			pend_q <= 1'b0;
			cond_q <= 1'b0;
			event_q <= 1'b0;
			rdata_q <= CFG_RESET;
			hyst_qdeg_q <= HQ_NONE;
			pin_q <= ~CFG_RESET[B_POL];
			oe_b_q <= ~CFG_RESET[B_OUT_EN];
		end else begin
			mode_q <= mode_d;
			pol_q <= pol_d;
			crit_only_q <= crit_only_d;
			out_en_q <= out_en_d;
			alarm_lock_q <= alarm_lock_d;
			crit_lock_q <= crit_lock_d;
			shutdown_q <= shutdown_d;
			hyst_q <= hyst_d;
			pend_q <= pend_d;
			cond_q <= cond_d;
			event_q <= event_d;
			rdata_q <= rdata_d;
			hyst_qdeg_q <= hyst_qdeg_d;
			pin_q <= pin_d;
			oe_b_q <= oe_b_d;
		end
	end

	// Trip register write permits; combinational so the front end stalls nothing
	assign ALARM_TRIP_WR_EN = ALARM_TRIP_WR_REQ & ~alarm_lock_q;
	assign CRIT_TRIP_WR_EN = CRIT_TRIP_WR_REQ & ~crit_lock_q;
	assign THERMAL_SENSING_EN = ~shutdown_q;
	assign HYST_QDEG = hyst_qdeg_q;
	assign CFG_RDATA = rdata_q;
	// Pin level is the active level when asserted; disabled output releases the pin
	assign EVENT_O = pin_q;
	assign EVENT_OE_B = oe_b_q;

	// Steps of the event path that the properties below are built from
	sequence s_clr_wr;
		CFG_WR_STB && CFG_WDATA[B_CLEAR];
	endsequence
	sequence s_comp_clr;
		!mode_q && !shutdown_q && cond && CFG_WR_STB && CFG_WDATA[B_CLEAR];
	endsequence
	sequence s_trip_edge;
		mode_q && !shutdown_q && cond && !cond_q;
	endsequence
	sequence s_int_clear;
		mode_q && !shutdown_q && CFG_WR_STB && CFG_WDATA[B_CLEAR] && !ABOVE_CRIT && !(cond && !cond_q);
	endsequence
	sequence s_crit_clr;
		mode_q && !shutdown_q && ABOVE_CRIT && CFG_WR_STB && CFG_WDATA[B_CLEAR];
	endsequence

	crit_only_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(!mode_q && crit_only_q && !shutdown_q && !ABOVE_CRIT) |=> !event_q)
		else $error("critical-only event without critical trip");
	lock_freeze_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		locked |=> $stable({mode_q, pol_q, crit_only_q, out_en_q}))
		else $error("locked event field changed");
	status_bit_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CFG_RDATA[B_STATUS] == (event_q & out_en_q))
		else $error("status bit mismatch");
	comp_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		s_comp_clr |=> event_q)
		else $error("comparator event cleared by clear bit");
	clear_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!CFG_RDATA[B_CLEAR] && CFG_RDATA[CFG_W-1:B_HYST_HI+1] == '0)
		else $error("write-only or reserved bit reads nonzero");
	crit_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(mode_q && !shutdown_q && ABOVE_CRIT) ##1 (mode_q && !shutdown_q) |-> event_q)
		else $error("event dropped above critical limit");
	lock_sticky_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(alarm_lock_q || crit_lock_q) |=> (alarm_lock_q >= $past(alarm_lock_q)) &&
			(crit_lock_q >= $past(crit_lock_q)))
		else $error("lock bit cleared without reset");
	lock_single_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(CFG_WR_STB && CFG_WDATA[B_CRIT_LOCK]) |=> crit_lock_q ##1 !CRIT_TRIP_WR_EN[*2])
		else $error("critical lock not set by one write");
	shut_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(locked && !shutdown_q) |=> !shutdown_q)
		else $error("shutdown set while locked");
	shut_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		shutdown_q [*2] |=> !event_q)
		else $error("event during shutdown");
	// Disabled output releases the pin
	oe_pin_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		EVENT_OE_B == !out_en_q)
		else $error("output enable does not follow control bit");
	// Pin shows the active level chosen by polarity
	pin_level_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		EVENT_O == (event_q ? pol_q : !pol_q))
		else $error("event pin level wrong for polarity");
	// Comparator mode tracks the condition one edge later
	comp_follow_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		!mode_q |=> event_q == $past(cond))
		else $error("comparator event does not follow condition");
	// Interrupt mode latches a new trip
	int_latch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		s_trip_edge |=> event_q)
		else $error("interrupt trip not latched");
	// A clear below the critical limit drops the latched event
	clear_done_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		s_int_clear |=> !event_q)
		else $error("interrupt event not cleared");
	// Writing zero to the clear bit leaves a pending event alone
	clear_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(mode_q && !shutdown_q && pend_q && CFG_WR_STB && !CFG_WDATA[B_CLEAR]) |=> event_q)
		else $error("event cleared by zero write");
	// Above critical the clear request is refused
	crit_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		s_crit_clr |=> event_q)
		else $error("event cleared above critical limit");
	// Writing the status bit cannot raise an event
	status_wr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(CFG_WR_STB && CFG_WDATA[B_STATUS] && !mode_q && !cond) |=> !event_q)
		else $error("status write changed event");
	// Reserved bits stay zero after any write
	resv_wr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CFG_WR_STB |=> CFG_RDATA[CFG_W-1:B_HYST_HI+1] == '0)
		else $error("reserved bits stored a write");
	// The clear bit is never stored
	clear_wr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		s_clr_wr |=> !CFG_RDATA[B_CLEAR])
		else $error("clear bit read back as one");
	// Alarm lock refuses alarm boundary writes
	alarm_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		alarm_lock_q |-> !ALARM_TRIP_WR_EN)
		else $error("alarm trip write while locked");
	// Unlocked alarm boundaries take the write
	trip_open_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(!alarm_lock_q && ALARM_TRIP_WR_REQ) |-> ALARM_TRIP_WR_EN)
		else $error("alarm trip write refused while unlocked");
	// Critical lock refuses critical trip writes
	crit_lock_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		crit_lock_q |-> !CRIT_TRIP_WR_EN)
		else $error("critical trip write while locked");
	// Sensing stops whenever shutdown is set
	sense_off_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		THERMAL_SENSING_EN == !shutdown_q)
		else $error("sensing enable disagrees with shutdown");
	// Shutdown drops any pending interrupt
	shut_pend_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		shutdown_q |=> !pend_q)
		else $error("pending event kept in shutdown");
	// Hysteresis output matches the stored code
	hyst_map_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		HYST_QDEG == hyst_steps(hyst_q))
		else $error("hysteresis steps wrong");
	// Hysteresis field is written on every strobe, locked or not
	hyst_wr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		CFG_WR_STB |=> hyst_q == $past(CFG_WDATA[B_HYST_HI:B_HYST_LO]))
		else $error("hysteresis write lost");
	// Unlocked writes reach the event fields
	field_wr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(CFG_WR_STB && !locked) |=> mode_q == $past(CFG_WDATA[B_MODE]) && out_en_q == $past(CFG_WDATA[B_OUT_EN]))
		else $error("unlocked event field write lost");
	// One write is enough to set the alarm lock
	lock_set_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(CFG_WR_STB && CFG_WDATA[B_ALARM_LOCK]) |=> alarm_lock_q)
		else $error("alarm lock not set by one write");
	// Clearing shutdown is always accepted
	shut_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(CFG_WR_STB && !CFG_WDATA[B_SHUTDOWN]) |=> !shutdown_q)
		else $error("shutdown clear refused");
	// Alarm window trips raise events when not critical-only
	window_ev_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(!mode_q && !crit_only_q && !shutdown_q && (ABOVE_ALARM || BELOW_ALARM)) |=> event_q)
		else $error("alarm window event missing");
	// Critical-only still reports the critical trip
	crit_only_hi_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		(!mode_q && crit_only_q && !shutdown_q && ABOVE_CRIT) |=> event_q)
		else $error("critical event missing in critical-only");
endmodule

// >>> thermal_event_config_register_tb.sv
/*
 Self-checking bench for the event and power configuration register.
 Assumes one 100 MHz clock and the host model as the only writer.
*/
`timescale 1ns/1ps
module thermal_event_config_register_tb;
	import thermal_cfg_pkg::*;
	logic              clk, rst_b, ac, aa, ba, a_req, c_req, stb, a_en, c_en, sen, ev, oe_b;
	logic [CFG_W-1:0]  wdata, rdata;
	logic [HYST_W-1:0] hq;
	int                miscompares, checks, cycles;
	logic [1:0]        c;
	cfg_host_model i_host (.CORE_CLK(clk), .stb(stb), .wdata(wdata));
	thermal_event_config_register i_dut (.CORE_CLK(clk), .RST_B(rst_b), .CFG_WR_STB(stb),
		.CFG_WDATA(wdata), .CFG_RDATA(rdata), .ABOVE_CRIT(ac), .ABOVE_ALARM(aa),
		.BELOW_ALARM(ba), .ALARM_TRIP_WR_REQ(a_req), .CRIT_TRIP_WR_REQ(c_req),
		.ALARM_TRIP_WR_EN(a_en), .CRIT_TRIP_WR_EN(c_en), .THERMAL_SENSING_EN(sen),
		.HYST_QDEG(hq), .EVENT_O(ev), .EVENT_OE_B(oe_b));
	always #5 clk = ~clk;
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Read data lags the strobe by one cycle, so two edges are let pass
	task automatic wr(input logic [15:0] w);
		i_host.send(w);
		tick(2);
	endtask
	function automatic logic cond(input logic co, input logic x, input logic y, input logic z);
		return co ? x : (x | y | z);
	endfunction
	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{clk, rst_b, ac, aa, ba, a_req, c_req} = 7'h00;
		void'($urandom(32'h572b));
		tick(10);
		rst_b = 1'b1;
		chk("rdata", rdata, 16'h0000);
		chk("oe_b", oe_b, 1'b1);
		chk("sense", sen, 1'b1);
		chk("event", ev, 1'b1);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(16'hF820 | (16'(c) << 9));
			chk("hyst", hq, (c == 0) ? 16'h0000 : (16'h0006 << (c - 1)));
			chk("rdata", rdata, 16'(c) << 9);
		end
		$display("hysteresis test done");
		// Random levels against the comparator, crit-only and polarity high
		for (int i = 0; i < 24; i++) begin
			c = 2'($urandom_range(0, 1));
			wr(16'h000A | (16'(c) << 2));
			{ac, aa, ba} = 3'($urandom);
			tick(3);
			chk("event", ev, cond(c[0], ac, aa, ba));
			chk("status", rdata[4], cond(c[0], ac, aa, ba));
		end
		{ac, aa, ba} = 3'h0;
		$display("random comparator test done");
		wr(16'h0018);
		chk("rdata", rdata, 16'h0008);
		chk("oe_b", oe_b, 1'b0);
		chk("event", ev, 1'b1);
		aa = 1'b1;
		tick(3);
		chk("event", ev, 1'b0);
		chk("rdata", rdata, 16'h0018);
		wr(16'h0028);
		chk("event", ev, 1'b0);
		wr(16'h0000);
		chk("oe_b", oe_b, 1'b1);
		aa = 1'b0;
		wr(16'h0009);
		aa = 1'b1;
		tick(2);
		aa = 1'b0;
		tick(3);
		chk("event", ev, 1'b0);
		wr(16'h0029);
		chk("event", ev, 1'b1);
		chk("rdata", rdata, 16'h0009);
		ac = 1'b1;
		tick(3);
		wr(16'h0029);
		chk("event", ev, 1'b0);
		ac = 1'b0;
		$display("event test done");
		aa = 1'b1;
		wr(16'h0108);
		chk("sense", sen, 1'b0);
		chk("event", ev, 1'b1);
		aa = 1'b0;
		wr(16'h0148);
		{a_req, c_req} = 2'h3;
		tick(1);
		chk("alarm_en", a_en, 1'b0);
		chk("crit_en", c_en, 1'b1);
		wr(16'h0001);
		chk("rdata", rdata, 16'h0048);
		wr(16'h0101);
		chk("rdata", rdata, 16'h0048);
		wr(16'h0080);
		chk("crit_en", c_en, 1'b0);
		wr(16'h0000);
		chk("rdata", rdata, 16'h00C8);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		tick(2);
		chk("rdata", rdata, 16'h0000);
		chk("alarm_en", a_en, 1'b1);
		$display("lock test done");
		test_done();
	end
endmodule
